// ===== rtl/qar_readout.sv
// Contract
// - Every accepted telegram for this module starts all four converters together.
// - A telegram returns the last results completed before it, from the previous cycle or older after a timeout, never the new one.
// - All converter control is made inside; the master sends no selection or commands.
// - Each result is a 12-bit unsigned code and two of them travel in one telegram.
// - Every 32-bit answer word holds the readings of two converters side by side.
// - The module answers at two consecutive addresses and the master reserves both.
// - The link runs at 2.5 megabaud and one 32-bit word occupies a 25 us slot.
// - Without faults only the two green cycle lamps are lit and both red lamps stay dark.
// - A detected fault lights one or both red lamps according to the kind of fault.
// - Unipolar ranges read straight binary, zero as 000 and full scale as fff.
// - Bipolar ranges read offset binary, zero as 800 and negative full scale as 000.
`include "qar_defines.svh"

module qar_readout
   import qar_pkg::*;
#(
   parameter int NUM_CH = `QAR_NUM_CH,
   parameter int BAUD_DIV = `QAR_BAUD_DIV,
   parameter int SLOT_CYC = `QAR_SLOT_CYC,
   parameter int CONV_TMO_CYC = `QAR_CONV_TMO_CYC,
   parameter int LED_HOLD_CYC = `QAR_LED_HOLD_CYC
) (
   input wire logic core_clk, // system clock, 10 MHz
   input wire logic rst, // synchronous reset, high
   input wire logic tel_rx_strobe, // pulse: telegram for this module received
   input wire logic tel_rx_addr, // 0 = first address, 1 = second address
   output logic tel_accept, // pulse: telegram taken, cycle strobe
   output logic [31:0] tx_word, // answer word of the running slot
   output logic tx_bit, // serial answer, lsb first
   output logic tx_active, // answer slot running
   output logic [3:0] adc_start, // pulse per converter: begin conversion
   input wire logic [3:0] adc_done, // pulse per converter: result valid
   input wire logic [3:0][11:0] adc_result, // converter output codes
   output logic [1:0] led_cycle_green, // green cycle lamps, one per logic half
   output logic [1:0] led_error_red // red lamps: [0] converter, [1] link
);
   localparam int DW = $clog2(BAUD_DIV + 1);
   localparam int SW = $clog2(SLOT_CYC + 1);
   localparam int LW = $clog2(LED_HOLD_CYC + 1);

   // ****************************************
   // decode helpers
   // ****************************************
   // packs two channel codes into one answer word, upper pad bits zero
   function automatic logic [31:0] qar_pack(input qar_code_t lo, input qar_code_t hi);
      qar_pack = {`QAR_PAD_W'(0), hi, `QAR_PAD_W'(0), lo};
   endfunction : qar_pack

   // true when the telegram addresses the given half of the module
   function automatic logic qar_half_hit(input logic addr, input int half);
      qar_half_hit = (addr == half[0]);
   endfunction : qar_half_hit

   // true when either converter of an address half has timed out
   function automatic logic qar_half_fault(input logic [NUM_CH-1:0] f, input int half);
      qar_half_fault = f[2 * half] || f[2 * half + 1];
   endfunction : qar_half_fault

   // ****************************************
   // converter control instances
   // ****************************************
   qar_code_t held [NUM_CH];
   logic [NUM_CH-1:0] conv_fault;
   logic cycle_strobe;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_conv
         qar_conv_if cv ();
         assign cv.cycle = cycle_strobe;
         assign cv.done = adc_done[gi];
         assign cv.result = adc_result[gi];
         assign adc_start[gi] = cv.start;
         assign held[gi] = cv.held;
         assign conv_fault[gi] = cv.fault;
         qar_conv_ctrl #(
            .TMO_CYC(CONV_TMO_CYC)
         ) u_conv (
            .core_clk(core_clk),
            .rst(rst),
            .cv(cv.ctrl)
         );
      end
   endgenerate

   // ****************************************
   // telegram acceptance
   // ****************************************
   qar_tx_state_e tx_state_r;
   logic [SW-1:0] slot_r;
   logic [DW-1:0] baud_r;
   logic [`QAR_BIT_CNT_W-1:0] bit_cnt_r;
   logic [31:0] shift_r;
   logic [31:0] tx_word_r;
   logic tx_bit_r;
   logic link_err_evt;

   // a telegram that lands inside a running slot overlaps the answer and is dropped
   assign cycle_strobe = tel_rx_strobe && (tx_state_r == QAR_TX_IDLE);
   assign link_err_evt = tel_rx_strobe && (tx_state_r != QAR_TX_IDLE);
   assign tel_accept = cycle_strobe;

   // ****************************************
   // bit timing enables
   // ****************************************
   // one enable pulse per bit time from the divider; the first bit has its
   // own launch pulse so that it leaves right after acceptance
   logic baud_tick;
   logic first_bit;
   logic word_sent;
   logic slot_over;

   assign baud_tick = (tx_state_r == QAR_TX_SEND) && (baud_r == DW'(BAUD_DIV - 1));
   assign first_bit = (tx_state_r == QAR_TX_SEND) && (baud_r == DW'(0))
                      && (bit_cnt_r == '0) && (slot_r == '0);
   // the word ends only after the last bit has stood its full bit time
   assign word_sent = baud_tick && (bit_cnt_r == `QAR_BIT_CNT_W'(`QAR_WORD_W));
   // the slot ends 25 us after it began, whatever the bit count
   assign slot_over = (tx_state_r == QAR_TX_GAP) && (slot_r >= SW'(SLOT_CYC - 2));

   // ****************************************
   // answer word capture
   // ****************************************
   // held still shows the previous cycle here: the new conversion has just
   // been started and cannot finish in the same edge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tx_word_r <= '0;
      end else if (cycle_strobe) begin
         if (qar_half_hit(tel_rx_addr, 0)) begin
            tx_word_r <= qar_pack(held[0], held[1]);
         end else begin
            tx_word_r <= qar_pack(held[2], held[3]);
         end
      end
   end

   // ****************************************
   // slot sequencer
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tx_state_r <= QAR_TX_IDLE;
         slot_r <= '0;
      end else begin
         unique case (tx_state_r)
            QAR_TX_IDLE: begin
               slot_r <= '0;
               if (cycle_strobe) begin
                  tx_state_r <= QAR_TX_SEND;
               end
            end
            QAR_TX_SEND: begin
               slot_r <= slot_r + SW'(1);
               if (word_sent) begin
                  tx_state_r <= QAR_TX_GAP;
               end
            end
            QAR_TX_GAP: begin
               // the slot ends 25 us after it began, whatever the bit count
               slot_r <= slot_r + SW'(1);
               if (slot_over) begin
                  tx_state_r <= QAR_TX_IDLE;
               end
            end
            default: begin
               tx_state_r <= QAR_TX_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // baud divider
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         baud_r <= '0;
      end else if (tx_state_r != QAR_TX_SEND) begin
         baud_r <= '0;
      end else if (baud_tick) begin
         baud_r <= '0;
      end else begin
         baud_r <= baud_r + DW'(1);
      end
   end

   // ****************************************
   // bit counter
   // ****************************************
   // counts one past the word so that the last bit keeps its full time
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bit_cnt_r <= '0;
      end else if (cycle_strobe) begin
         bit_cnt_r <= '0;
      end else if (first_bit) begin
         bit_cnt_r <= `QAR_BIT_CNT_W'(1);
      end else if (baud_tick) begin
         bit_cnt_r <= bit_cnt_r + `QAR_BIT_CNT_W'(1);
      end
   end

   // ****************************************
   // serialiser
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         shift_r <= '0;
         tx_bit_r <= 1'b0;
      end else if (cycle_strobe) begin
         shift_r <= '0;
         tx_bit_r <= 1'b0;
      end else if (first_bit) begin
         // first bit is loaded the cycle after acceptance and shows on tx_bit two cycles after it
         shift_r <= {1'b0, tx_word_r[31:1]};
         tx_bit_r <= tx_word_r[0];
      end else if (baud_tick) begin
         if (bit_cnt_r < `QAR_BIT_CNT_W'(`QAR_WORD_W)) begin
            tx_bit_r <= shift_r[0];
            shift_r <= {1'b0, shift_r[31:1]};
         end else begin
            tx_bit_r <= 1'b0;
         end
      end else if (tx_state_r != QAR_TX_SEND) begin
         tx_bit_r <= 1'b0;
      end
   end

   assign tx_word = tx_word_r;
   assign tx_bit = tx_bit_r;
   assign tx_active = (tx_state_r != QAR_TX_IDLE);

   // ****************************************
   // cycle lamps, one per address half
   // ****************************************
   // a lamp stays lit while its address is polled; a stalled master
   // lets it go dark after the hold time
   logic [LW-1:0] green_hold_r [2];

   generate
      for (gi = 0; gi < 2; gi++) begin : g_green
         always_ff @(posedge core_clk) begin
            if (rst) begin
               green_hold_r[gi] <= '0;
            end else if (cycle_strobe && qar_half_hit(tel_rx_addr, gi)) begin
               green_hold_r[gi] <= LW'(LED_HOLD_CYC);
            end else if (green_hold_r[gi] != '0) begin
               green_hold_r[gi] <= green_hold_r[gi] - LW'(1);
            end
         end
      end
   endgenerate

   // ****************************************
   // error lamps
   // ****************************************
   logic [LW-1:0] link_hold_r;
   logic [1:0] green_r;
   logic [1:0] red_r;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         link_hold_r <= '0;
      end else if (link_err_evt) begin
         link_hold_r <= LW'(LED_HOLD_CYC);
      end else if (link_hold_r != '0) begin
         link_hold_r <= link_hold_r - LW'(1);
      end
   end

   // the converter lamp follows the fault flags; the link lamp is stretched
   // so that a single overlapping telegram stays visible
   always_ff @(posedge core_clk) begin
      if (rst) begin
         red_r <= 2'h0;
      end else begin
         red_r[0] <= |conv_fault;
         red_r[1] <= (link_hold_r != '0) || link_err_evt;
      end
   end

   // a half with a timed-out converter shows red instead of green
   always_ff @(posedge core_clk) begin
      if (rst) begin
         green_r <= 2'h0;
      end else begin
         green_r[0] <= (green_hold_r[0] != '0) && !qar_half_fault(conv_fault, 0);
         green_r[1] <= (green_hold_r[1] != '0) && !qar_half_fault(conv_fault, 1);
      end
   end

   assign led_cycle_green = green_r;
   assign led_error_red = red_r;
endmodule : qar_readout

// ===== rtl/qar_defines.svh
`ifndef QAR_DEFINES_SVH
`define QAR_DEFINES_SVH

// ****************************************
// widths and layout
// ****************************************
`define QAR_NUM_CH 4
`define QAR_RES_W 12
`define QAR_HALF_W 16
`define QAR_WORD_W 32
`define QAR_PAD_W 4
`define QAR_BIT_CNT_W 6

// ****************************************
// timing
// ****************************************
`define QAR_CLK_HZ 10000000
`define QAR_CLK_NS 100
`define QAR_BAUD_HZ 2500000
`define QAR_BAUD_DIV (`QAR_CLK_HZ / `QAR_BAUD_HZ)
`define QAR_SLOT_NS 25000
`define QAR_SLOT_CYC (`QAR_SLOT_NS / `QAR_CLK_NS)
`define QAR_CONV_NS 10000
`define QAR_CONV_CYC ((`QAR_CONV_NS + `QAR_CLK_NS - 1) / `QAR_CLK_NS)
`define QAR_CONV_TMO_CYC (2 * `QAR_CONV_CYC)
`define QAR_LED_HOLD_MS 100
`define QAR_LED_HOLD_CYC (`QAR_LED_HOLD_MS * (`QAR_CLK_HZ / 1000))

`endif

// ===== rtl/qar_pkg.sv
package qar_pkg;
   typedef enum logic [0:0] {
      QAR_CONV_IDLE = 1'b0,
      QAR_CONV_BUSY = 1'b1
   } qar_conv_state_e;

   typedef enum logic [1:0] {
      QAR_TX_IDLE = 2'b00,
      QAR_TX_SEND = 2'b01,
      QAR_TX_GAP = 2'b10
   } qar_tx_state_e;

   typedef logic [11:0] qar_code_t;
endpackage : qar_pkg

// ===== rtl/qar_conv_if.sv
interface qar_conv_if;
   import qar_pkg::*;
   logic cycle;
   logic start;
   logic done;
   qar_code_t result;
   qar_code_t held;
   logic fault;
   logic busy;

   modport ctrl (
      input cycle, done, result,
      output start, held, fault, busy
   );

   modport top (
      output cycle, done, result,
      input start, held, fault, busy
   );
endinterface : qar_conv_if

// ===== rtl/qar_conv_ctrl.sv
`include "qar_defines.svh"

module qar_conv_ctrl
   import qar_pkg::*;
#(
   parameter int TMO_CYC = `QAR_CONV_TMO_CYC
) (
   input wire logic core_clk, // system clock
   input wire logic rst, // synchronous reset, high
   qar_conv_if.ctrl cv // one converter's control and results
);
   localparam int CW = $clog2(TMO_CYC + 1);

   qar_conv_state_e state_r;
   logic [CW-1:0] tmo_r;
   logic start_r;
   qar_code_t held_r;
   logic fault_r;

   // ****************************************
   // start pulse and conversion tracking
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= QAR_CONV_IDLE;
         tmo_r <= '0;
         start_r <= 1'b0;
      end else begin
         // the start is made here, nothing is asked of the bus master
         start_r <= cv.cycle;
         if (cv.cycle) begin
            // a new cycle restarts even an unfinished conversion
            state_r <= QAR_CONV_BUSY;
            tmo_r <= '0;
         end else begin
            unique case (state_r)
               QAR_CONV_IDLE: begin
                  tmo_r <= '0;
               end
               QAR_CONV_BUSY: begin
                  if (cv.done || tmo_r == CW'(TMO_CYC - 1)) begin
                     state_r <= QAR_CONV_IDLE;
                  end
                  tmo_r <= tmo_r + CW'(1);
               end
            endcase
         end
      end
   end

   // ****************************************
   // completed result holding register
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         held_r <= '0;
      end else if (state_r == QAR_CONV_BUSY && cv.done && !cv.cycle) begin
         // codes pass unchanged: straight binary or offset binary by range
         held_r <= cv.result;
      end
   end

   // ****************************************
   // fault: timeout sets, a good completion clears
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fault_r <= 1'b0;
      end else if (state_r == QAR_CONV_BUSY && !cv.done && !cv.cycle
                   && tmo_r == CW'(TMO_CYC - 1)) begin
         fault_r <= 1'b1;
      end else if (state_r == QAR_CONV_BUSY && cv.done && !cv.cycle) begin
         fault_r <= 1'b0;
      end
   end

   assign cv.start = start_r;
   assign cv.held = held_r;
   assign cv.fault = fault_r;
   assign cv.busy = (state_r == QAR_CONV_BUSY);
endmodule : qar_conv_ctrl

// ===== test/qar_readout_sva.sv
module qar_readout_sva (
   input wire logic core_clk, // system clock
   input wire logic rst, // synchronous reset, high
   input wire logic tel_rx_strobe, // telegram strobe
   input wire logic tel_accept, // cycle strobe
   input wire logic [31:0] tx_word, // answer word
   input wire logic tx_bit, // serial answer
   input wire logic tx_active, // slot running
   input wire logic [3:0] adc_start, // converter starts
   input wire logic [1:0] led_error_red // red lamps
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // port relations
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_acc; tel_accept == (tel_rx_strobe && !tx_active); endproperty
   a_acc: assert property (p_acc) else $error("cycle strobe mismatch");
   property p_start; tel_accept |=> adc_start == 4'hf; endproperty
   a_start: assert property (p_start) else $error("converters not all started");
   property p_nostart; adc_start != 4'h0 |-> $past(tel_accept); endproperty
   a_nostart: assert property (p_nostart) else $error("start without telegram");
   property p_hold; !tel_accept |=> $stable(tx_word); endproperty
   a_hold: assert property (p_hold) else $error("answer word changed");
   property p_pad; tx_word[15:12] == 4'h0 && tx_word[31:28] == 4'h0; endproperty
   a_pad: assert property (p_pad) else $error("pad bits set");
   property p_slot; tel_accept |-> ##249 tx_active ##1 !tx_active; endproperty
   a_slot: assert property (p_slot) else $error("slot length wrong");
   property p_bit0; tel_accept |-> ##2 tx_bit == tx_word[0]; endproperty
   a_bit0: assert property (p_bit0) else $error("first bit wrong");
   property p_idle; !tx_active |-> !tx_bit; endproperty
   a_idle: assert property (p_idle) else $error("line busy when idle");
   property p_ovl; tel_rx_strobe && tx_active |-> ##[1:2] led_error_red[1]; endproperty
   a_ovl: assert property (p_ovl) else $error("overlap lamp dark");
   c_acc: cover property (tel_accept);
   c_ovl: cover property (tel_rx_strobe && tx_active);
   c_red0: cover property ($rose(led_error_red[0]));
endmodule : qar_readout_sva

bind qar_readout qar_readout_sva u_sva (.core_clk(core_clk), .rst(rst),
   .tel_rx_strobe(tel_rx_strobe), .tel_accept(tel_accept), .tx_word(tx_word),
   .tx_bit(tx_bit), .tx_active(tx_active), .adc_start(adc_start),
   .led_error_red(led_error_red));

// ===== test/qar_master_model.sv
module qar_master_model (
   input wire logic core_clk, // system clock
   input wire logic tel_accept, // cycle strobe
   input wire logic tx_bit, // serial answer
   input wire logic tx_active, // slot running
   output logic tel_rx_strobe, // telegram strobe
   output logic tel_rx_addr // address select
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      tel_rx_strobe = 1'b0;
      tel_rx_addr = 1'b0;
   end
   // bare strobe, used to hit a running slot
   task automatic kick(input logic a);
      @(posedge core_clk);
      tel_rx_strobe <= 1'b1;
      tel_rx_addr <= a;
      @(posedge core_clk);
      tel_rx_strobe <= 1'b0;
      tel_rx_addr <= ~a;
   endtask : kick
   // one telegram: strobe, then 32 bits lsb first, the first sampled after 3 clocks and the rest 4 clocks apart
   task automatic poll(input logic a, output logic [31:0] w);
      int n;
      kick(a);
      for (int k = 0; k < 32; k++) begin
         repeat (k == 0 ? 3 : 4) @(posedge core_clk);
         @(negedge core_clk);
         w[k] = tx_bit;
      end
      n = 0;
      while (tx_active && n < 300) begin
         @(negedge core_clk);
         n++;
      end
   endtask : poll
endmodule : qar_master_model

// ===== test/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import qar_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic tel_rx_strobe, tel_rx_addr, tel_accept, tx_bit, tx_active;
   logic [31:0] tx_word, w;
   logic [3:0] adc_start;
   logic [3:0] adc_done = 4'h0;
   logic [3:0][11:0] adc_result = '0;
   logic [1:0] led_cycle_green, led_error_red;
   logic [3:0] conv_en = 4'hf;
   qar_code_t code [4] = '{default: 12'h000};
   int cnt [4] = '{default: 0};
   int mismatches = 0;
   int samples_checked = 0;

   initial forever #50 core_clk = ~core_clk;

   qar_readout #(.LED_HOLD_CYC(600)) dut (.core_clk(core_clk), .rst(rst),
      .tel_rx_strobe(tel_rx_strobe), .tel_rx_addr(tel_rx_addr), .tel_accept(tel_accept),
      .tx_word(tx_word), .tx_bit(tx_bit), .tx_active(tx_active), .adc_start(adc_start),
      .adc_done(adc_done), .adc_result(adc_result), .led_cycle_green(led_cycle_green),
      .led_error_red(led_error_red));
   qar_master_model m (.core_clk(core_clk), .tel_accept(tel_accept), .tx_bit(tx_bit),
      .tx_active(tx_active), .tel_rx_strobe(tel_rx_strobe), .tel_rx_addr(tel_rx_addr));

   // ****************************************
   // converters: result 20 clocks after start, lines scrambled otherwise
   // ****************************************
   always @(posedge core_clk) begin
      for (int i = 0; i < 4; i++) begin
         adc_done[i] <= 1'b0;
         adc_result[i] <= ~code[i];
         if (adc_start[i]) begin
            cnt[i] <= 20;
         end else if (cnt[i] > 0) begin
            cnt[i] <= cnt[i] - 1;
            if (cnt[i] == 1 && conv_en[i]) begin
               adc_done[i] <= 1'b1;
               adc_result[i] <= code[i];
            end
         end
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask : chk

   function automatic logic [31:0] pk(input qar_code_t lo, input qar_code_t hi);
      return {4'h0, hi, 4'h0, lo};
   endfunction : pk

   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_pipeline();
      code = '{12'hfff, 12'h000, 12'h800, 12'h123};
      m.poll(1'b0, w);
      chk(w, 32'h0, "first word");
      code = '{12'h7ff, 12'h801, 12'h001, 12'hffe};
      m.poll(1'b1, w);
      chk(w, pk(12'h800, 12'h123), "second address");
      chk(tx_word, pk(12'h800, 12'h123), "parallel word");
      m.poll(1'b0, w);
      chk(w, pk(12'h7ff, 12'h801), "first address");
      chk({30'h0, led_cycle_green}, 32'h3, "green lamps");
      chk({30'h0, led_error_red}, 32'h0, "red lamps");
   endtask : t_pipeline

   task automatic t_overlap();
      fork
         m.poll(1'b1, w);
         begin
            repeat (40) @(posedge core_clk);
            m.kick(1'b0);
         end
      join
      chk(w, pk(12'h001, 12'hffe), "word after overlap");
      chk(tx_word, pk(12'h001, 12'hffe), "held word");
      chk({31'h0, led_error_red[1]}, 32'h1, "link lamp");
   endtask : t_overlap

   task automatic t_fault();
      @(posedge core_clk);
      conv_en <= 4'b1011;
      m.poll(1'b0, w);
      chk(w, pk(12'h7ff, 12'h801), "word during fault");
      chk({31'h0, led_error_red[0]}, 32'h1, "converter lamp on");
      chk({31'h0, led_cycle_green[1]}, 32'h0, "faulty half green off");
      @(posedge core_clk);
      conv_en <= 4'hf;
      m.poll(1'b1, w);
      chk(w, pk(12'h001, 12'hffe), "result kept over timeout");
      chk({31'h0, led_error_red[0]}, 32'h0, "converter lamp off");
   endtask : t_fault

   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      t_pipeline();
      t_overlap();
      t_fault();
      close_out();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      close_out();
   end
endmodule : tb
